// [module_sideband_control.sv]
// sideband pin logic of a pluggable transceiver module: select gating,
// qualified reset with completion interrupt, low power request, presence
// and the open-collector interrupt line
// assumes pins arrive asynchronously; flag_condition and status_read come
// from the management memory logic on sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "sideband_defs.svh"

module module_sideband_control #(
    // least reset low width in cycles; shorten for simulation
    parameter int RESET_MIN_CYC = `SB_RESET_MIN_CYC,
    // initialisation interval in cycles; above 4096, shorten for simulation
    parameter int INIT_CYC      = `SB_INIT_CYC
) (
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    input  wire logic                 module_select_n_pin,
    input  wire logic                 module_reset_n,
    input  wire logic                 low_power_request,
    input  wire logic                 flag_condition,
    input  wire logic                 status_read,
    output var  logic                 mgmt_enable,
    output var  logic                 user_settings_reset,
    output var  logic                 data_not_ready,
    output var  logic                 low_power_mode,
    output var  logic                 interrupt_n_o,
    output var  logic                 interrupt_n_oe,
    output var  logic                 module_present_n_o,
    output var  logic                 module_present_n_oe,
    output var  sideband_pkg::init_state_t init_state
);
    import sideband_pkg::*;

    localparam int NP = `SB_NUM_PINS;
    localparam int NS = `SB_SYNC_STAGES;

    // a synchroniser needs two stages at least
    if (NS < 2) begin : g_bad_sync
        $error("module_sideband_control: synchroniser too shallow");
    end

    // raw pin vector, in the positions named by the header
    wire logic [NP-1:0] pin_raw;

    // synchronised pin vector
    wire logic [NP-1:0] pin_sync;

    // idle level of each pin while its synchroniser is in reset:
    // select and reset idle high through their pull-ups, low power idles low
    localparam logic [NP-1:0] PIN_IDLE = 3'h3;

    assign pin_raw[`SB_PIN_SELECT] = module_select_n_pin;
    assign pin_raw[`SB_PIN_RESET]  = module_reset_n;
    assign pin_raw[`SB_PIN_LOWPWR] = low_power_request;

    // one two-flop synchroniser per pin; stage one feeds stage two only
    genvar gi;
    for (gi = 0; gi < NP; gi++) begin : g_sync
        logic [NS-1:0] sync_ff;  // shift chain, bit 0 is the first stage

        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                sync_ff <= {NS{PIN_IDLE[gi]}};
            end else begin
                sync_ff <= {sync_ff[NS-2:0], pin_raw[gi]};
            end
        end

        assign pin_sync[gi] = sync_ff[NS-1];
    end

    // decoded pin levels
    wire logic module_select_n;  // synchronised select, low selects
    wire logic reset_pin_low;    // synchronised reset pin is low
    wire logic lowpwr_sync;      // synchronised low power request

    // a floating select reads high through the pull-up: deselected
    assign module_select_n = pin_sync[`SB_PIN_SELECT];
    assign reset_pin_low   = !pin_sync[`SB_PIN_RESET];
    assign lowpwr_sync     = pin_sync[`SB_PIN_LOWPWR];

    // reset qualification and initialisation timing
    rst_qual_if rq ();

    assign rq.pin_low = reset_pin_low;

    reset_sequencer #(
        .RESET_MIN_CYC (RESET_MIN_CYC),
        .INIT_CYC      (INIT_CYC)
    ) u_reset_sequencer (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .rq      (rq)
    );

    // registered outputs and the completion flag
    logic        mgmt_enable_ff;          // management slave may answer
    logic        user_reset_ff;           // user settings forced to defaults
    logic        data_not_ready_ff;       // status invalid while set
    logic        low_power_ff;            // reduced power state selected
    logic        completion_pend_ff;      // reset completion not yet read
    logic        int_oe_ff;               // pulling the interrupt line low
    logic        int_o_ff;                // driven level, always low
    logic        present_o_ff;            // driven presence level, low
    logic        present_oe_ff;           // presence driver enabled
    init_state_t state_ff;                // copy of sequencer state

    // next values
    wire logic nxt_mgmt_enable;
    wire logic nxt_completion_pend;
    wire logic nxt_int_oe;
    wire logic valid_flag;

    // the bus is answered only with select low; with select high all
    // traffic is ignored, and nothing is answered while reset is held
    // since user settings are being wiped
    assign nxt_mgmt_enable = !module_select_n   // [RULE1]
                             && !rq.held;       // [RULE2]

    // completion is posted at the end of every initialisation, both
    // after power-up and after a pin reset; the host read clears it,
    // but a completion in the same cycle as the read wins
    assign nxt_completion_pend = rq.done ? 1'b1 :                  // [RULE6] [RULE7]
                                 rq.held ? 1'b0 :
                                 status_read ? 1'b0 :              // [RULE16]
                                 completion_pend_ff;

    // flags are not trusted while initialising, so a stale flag from
    // the memory logic cannot fake a completion interrupt
    assign valid_flag = flag_condition && !rq.busy;

    // line pulled low while anything remains pending; released once the
    // completion was read and the memory logic reports no flag left
    assign nxt_int_oe = nxt_completion_pend   // [RULE10]
                        || valid_flag;        // [RULE16]

    // control registers; every output except the constant interrupt and presence drivers comes straight from these
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mgmt_enable_ff     <= 1'b0;
            user_reset_ff      <= 1'b1;
            data_not_ready_ff  <= 1'b1;
            low_power_ff       <= 1'b0;
            completion_pend_ff <= 1'b0;
            int_oe_ff          <= 1'b0;
            state_ff           <= ST_POWERUP;
        end else begin
            mgmt_enable_ff     <= nxt_mgmt_enable;
            user_reset_ff      <= rq.held;                         // [RULE3]
            data_not_ready_ff  <= rq.busy;                         // [RULE6]
            low_power_ff       <= lowpwr_sync;                     // [RULE8]
            completion_pend_ff <= nxt_completion_pend;
            int_oe_ff          <= nxt_int_oe;                      // [RULE12]
            state_ff           <= rq.state;
        end
    end

    // constant drivers, kept in flops so every output is registered;
    // the interrupt pin never drives high, it only sinks or floats
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            int_o_ff      <= 1'b0;                                 // [RULE12]
            present_o_ff  <= 1'b0;                                 // [RULE9]
            present_oe_ff <= 1'b1;                                 // [RULE9]
        end else begin
            int_o_ff      <= 1'b0;
            present_o_ff  <= 1'b0;
            present_oe_ff <= 1'b1;
        end
    end

    // port drive
    assign mgmt_enable         = mgmt_enable_ff;
    assign user_settings_reset = user_reset_ff;
    assign data_not_ready      = data_not_ready_ff;
    assign low_power_mode      = low_power_ff;
    assign interrupt_n_o       = int_o_ff;
    assign interrupt_n_oe      = int_oe_ff;
    assign module_present_n_o  = present_o_ff;
    assign module_present_n_oe = present_oe_ff;
    assign init_state          = state_ff;

endmodule : module_sideband_control

`default_nettype wire

// [sideband_defs.svh]
// constants of the module sideband control block: timing figures and counts
// assumes a single 100 MHz system clock; included by its bare name
//
// Overview of operation
// RULE1: select low lets module answer management bus
// RULE2: select high ignores bus; pulled up, deselected
// RULE3: qualified long reset low restores all defaults
// RULE4: initialisation starts on reset rising edge
// RULE5: host ignores status until reset completes
// RULE6: completion shown by interrupt with ready flag
// RULE7: power-up raises completion interrupt unprompted
// RULE8: low power input high selects reduced power
// RULE9: presence line held grounded while inserted
// RULE10: interrupt line low flags fault or status
// RULE11: host reads management bus for source
// RULE12: interrupt is open collector, pull low only
// RULE13: host pulls lines up, 4.7k to 10k
// RULE14: host reads flag field after interrupt
// RULE15: short reset pulses are ignored entirely
// RULE16: interrupt released once flags read, none new
`ifndef SIDEBAND_DEFS_SVH
`define SIDEBAND_DEFS_SVH

// system clock period in ns
`define SB_CLK_PERIOD_NS 10
// least reset low time that counts as a reset, in ns
`define SB_T_RESET_MIN_NS 10000
// module initialisation interval after reset release, in ns
`define SB_T_INIT_NS 2000000
// least time rounds up to whole cycles
`define SB_RESET_MIN_CYC ((`SB_T_RESET_MIN_NS + `SB_CLK_PERIOD_NS - 1) / `SB_CLK_PERIOD_NS)
// interval rounds down to whole cycles, with no lower clamp
`define SB_INIT_CYC (`SB_T_INIT_NS / `SB_CLK_PERIOD_NS)
// synchroniser depth for pin inputs
`define SB_SYNC_STAGES 2
// number of sampled sideband pins: select, reset, low power
`define SB_NUM_PINS 3
// pin positions inside the synchroniser vector
`define SB_PIN_SELECT 0
`define SB_PIN_RESET 1
`define SB_PIN_LOWPWR 2

`endif

// [sideband_pkg.sv]
// types shared by the sideband control modules
// assumes the constants header is compiled alongside
package sideband_pkg;

    // reset and initialisation sequencer states
    typedef enum logic [1:0] {
        ST_POWERUP = 2'b00,  // first cycle after power-on reset
        ST_HELD    = 2'b01,  // qualified reset low on the pin
        ST_INIT    = 2'b10,  // initialisation interval running
        ST_READY   = 2'b11   // module operational
    } init_state_t;

endpackage : sideband_pkg

// [rst_qual_if.sv]
// carrier between the sideband top and its reset sequencer
// assumes both ends run on sys_clk
`timescale 1ns/1ps
`default_nettype none

interface rst_qual_if;
    import sideband_pkg::*;
    logic        pin_low;    // synchronised reset pin is low
    logic        held;       // module held in full reset
    logic        busy;       // reset or initialisation not complete
    logic        done;       // one-cycle pulse at end of initialisation
    init_state_t state;      // sequencer state

    modport seq (input pin_low, output held, output busy, output done, output state);
    modport ctrl (output pin_low, input held, input busy, input done, input state);
endinterface : rst_qual_if

`default_nettype wire

// [reset_sequencer.sv]
// qualifies the reset pin pulse width and times the initialisation interval
// assumes pin_low is already synchronised to sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "sideband_defs.svh"

module reset_sequencer #(
    parameter int RESET_MIN_CYC = `SB_RESET_MIN_CYC,
    parameter int INIT_CYC      = `SB_INIT_CYC
) (
    input wire logic sys_clk,
    input wire logic resetn,
    rst_qual_if.seq  rq
);
    import sideband_pkg::*;

    localparam int LW = $clog2(RESET_MIN_CYC + 1);
    localparam int TW = $clog2(INIT_CYC + 1);

    // refuse counts the counters cannot hold
    if (RESET_MIN_CYC < 1 || INIT_CYC < 1) begin : g_bad_param
        $error("reset_sequencer: counts must be at least one cycle");
    end

    logic [LW-1:0] low_cnt_ff;      // cycles the pin has stayed low
    logic [LW-1:0] nxt_low_cnt;
    logic [TW-1:0] timer_ff;        // cycles left in initialisation
    logic [TW-1:0] nxt_timer;
    init_state_t   state_ff;
    init_state_t   nxt_state;
    logic          done_ff;
    logic          nxt_done;
    wire logic     qualified;       // low for longer than the least width
    wire logic     timer_zero;

    // saturating count; a pulse shorter than the least width never qualifies
    assign nxt_low_cnt = !rq.pin_low ? '0 :
                         (low_cnt_ff == LW'(RESET_MIN_CYC)) ? low_cnt_ff :
                         low_cnt_ff + LW'(1);
    assign qualified   = rq.pin_low && (low_cnt_ff == LW'(RESET_MIN_CYC)); // [RULE15]
    assign timer_zero  = (timer_ff == '0);

    // next state
    always_comb begin
        nxt_state = state_ff;
        nxt_timer = timer_ff;
        nxt_done  = 1'b0;
        case (state_ff)
            ST_POWERUP: begin
                // power-on starts initialisation with no pin reset needed
                nxt_state = ST_INIT;                                 // [RULE7]
                nxt_timer = TW'(INIT_CYC);
            end
            ST_HELD: begin
                if (!rq.pin_low) begin
                    // rising edge of the pin opens the interval
                    nxt_state = ST_INIT;                             // [RULE4]
                    nxt_timer = TW'(INIT_CYC);
                end
            end
            ST_INIT: begin
                if (qualified) begin
                    nxt_state = ST_HELD;                             // [RULE3]
                end else if (timer_zero) begin
                    nxt_state = ST_READY;
                    nxt_done  = 1'b1;
                end else begin
                    nxt_timer = timer_ff - TW'(1);
                end
            end
            ST_READY: begin
                if (qualified) begin
                    nxt_state = ST_HELD;                             // [RULE3]
                end
            end
            default: begin
                nxt_state = ST_POWERUP;
            end
        endcase
    end

    // state registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff   <= ST_POWERUP;
            timer_ff   <= '0;
            low_cnt_ff <= '0;
            done_ff    <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            timer_ff   <= nxt_timer;
            low_cnt_ff <= nxt_low_cnt;
            done_ff    <= nxt_done;
        end
    end

    assign rq.held  = (state_ff == ST_HELD);
    assign rq.busy  = (state_ff != ST_READY);
    assign rq.done  = done_ff;
    assign rq.state = state_ff;

endmodule : reset_sequencer

`default_nettype wire

// [sideband_monitor.sv]
// concurrent checks on the sideband pins of the transceiver module
// assumes it is bound into module_sideband_control on sys_clk
`timescale 1ns/1ps
`default_nettype none

module sideband_monitor #(
    parameter int RESET_MIN_CYC = 4,
    parameter int INIT_CYC      = 20
) (
    input wire logic                      sys_clk,
    input wire logic                      resetn,
    input wire logic                      module_select_n_pin,
    input wire logic                      module_reset_n,
    input wire logic                      low_power_request,
    input wire logic                      flag_condition,
    input wire logic                      status_read,
    input wire logic                      mgmt_enable,
    input wire logic                      user_settings_reset,
    input wire logic                      data_not_ready,
    input wire logic                      low_power_mode,
    input wire logic                      interrupt_n_o,
    input wire logic                      interrupt_n_oe,
    input wire logic                      module_present_n_o,
    input wire logic                      module_present_n_oe,
    input wire sideband_pkg::init_state_t init_state
);
    import sideband_pkg::*;
    // init bound leaves slack for sync and output register lag
    localparam int INIT_MAX = INIT_CYC + 8;
    logic [15:0] run_ff;   // current low run of the reset pin
    logic [15:0] last_ff;  // length of the run that ended last
    wire  [15:0] nxt_run = module_reset_n ? 16'h0000 : run_ff + 16'h0001;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // run lengths let a reset be traced back to a long enough pulse
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            run_ff  <= '0;
            last_ff <= '0;
        end else begin
            run_ff  <= nxt_run;
            last_ff <= (module_reset_n && run_ff != 16'h0000) ? run_ff : last_ff;
        end
    end

    a_sel_answer: assert property ((!module_select_n_pin && module_reset_n) [*6] |=> mgmt_enable)
        else $error("select low did not enable management");
    a_desel_quiet: assert property (module_select_n_pin [*4] |=> !mgmt_enable)
        else $error("management enabled while deselected");
    a_lp_enter: assert property (low_power_request [*4] |=> low_power_mode)
        else $error("low power request not followed");
    a_lp_leave: assert property (!low_power_request [*4] |=> !low_power_mode)
        else $error("low power mode stuck on");
    a_reset_defaults: assert property (user_settings_reset |-> data_not_ready && !interrupt_n_oe)
        else $error("held reset without defaults");
    a_short_ignored: assert property ($rose(user_settings_reset)
        |-> (run_ff >= RESET_MIN_CYC || last_ff >= RESET_MIN_CYC))
        else $error("reset taken from a short pulse");
    a_init_span: assert property ($fell(user_settings_reset)
        |-> data_not_ready [*8] ##[1:INIT_MAX] !data_not_ready)
        else $error("initialisation interval wrong");
    a_done_int: assert property ($fell(data_not_ready) |-> interrupt_n_oe)
        else $error("completion without interrupt");
    a_flag_int: assert property (flag_condition && !data_not_ready |=> interrupt_n_oe)
        else $error("flag did not raise interrupt");
    a_read_release: assert property (status_read && !flag_condition && !data_not_ready
        |=> !interrupt_n_oe)
        else $error("interrupt not released after read");
    a_int_pull_low: assert property (interrupt_n_o == 1'b0)
        else $error("interrupt line driven high");
    a_present_ground: assert property (module_present_n_oe && !module_present_n_o)
        else $error("presence line not grounded");

    c_powerup: cover property ($fell(data_not_ready));
    c_reset: cover property ($rose(user_settings_reset));
    c_flag: cover property (flag_condition && interrupt_n_oe);
endmodule : sideband_monitor

bind module_sideband_control sideband_monitor #(
    .RESET_MIN_CYC(RESET_MIN_CYC),
    .INIT_CYC     (INIT_CYC)
) u_sideband_monitor (
    .sys_clk, .resetn, .module_select_n_pin, .module_reset_n, .low_power_request,
    .flag_condition, .status_read, .mgmt_enable, .user_settings_reset, .data_not_ready,
    .low_power_mode, .interrupt_n_o, .interrupt_n_oe, .module_present_n_o,
    .module_present_n_oe, .init_state
);

`default_nettype wire

// [host_model.sv]
// host board side of the sideband pins: pin drivers and pull-ups
// assumes pins change only at the falling edge of sys_clk
`timescale 1ns/1ps
`default_nettype none

module host_model (
    input  wire logic sys_clk,
    input  wire logic interrupt_n_o,
    input  wire logic interrupt_n_oe,
    input  wire logic module_present_n_o,
    input  wire logic module_present_n_oe,
    output var  logic module_select_n_pin,
    output var  logic module_reset_n,
    output var  logic low_power_request,
    output wire logic interrupt_n,
    output wire logic module_present_n
);
    // released open-collector lines float to the board pull-up
    assign interrupt_n      = interrupt_n_oe ? interrupt_n_o : 1'b1;
    assign module_present_n = module_present_n_oe ? module_present_n_o : 1'b1;

    // idle pins: deselected, out of reset, full power
    initial begin
        module_select_n_pin = 1'b1;
        module_reset_n      = 1'b1;
        low_power_request   = 1'b0;
    end

    // select and low power levels, applied off the sampling edge
    task automatic set_pins(input logic sel_n, input logic lp);
        @(negedge sys_clk);
        module_select_n_pin = sel_n;
        low_power_request   = lp;
    endtask : set_pins

    task automatic set_reset(input logic level);
        @(negedge sys_clk);
        module_reset_n = level;
    endtask : set_reset
endmodule : host_model

`default_nettype wire

// [tb_top.sv]
// self-checking bench of the module sideband control block
// assumes short timing parameters so init and reset fit a short run
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import sideband_pkg::*;
    localparam int RST_CYC = 4;
    localparam int INI_CYC = 20;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic flag_condition = 1'b0;
    logic status_read = 1'b0;
    wire  sel_n, rst_n, lp_req, int_line, prs_line;
    wire  mgmt_en, usr_rst, dnr, lp_mode, int_o, int_oe, prs_o, prs_oe;
    init_state_t init_state;
    int   num_errors = 0;
    int   n_compared = 0;

    always #5 sys_clk = ~sys_clk;

    module_sideband_control #(.RESET_MIN_CYC(RST_CYC), .INIT_CYC(INI_CYC))
    u_module_sideband_control (
        .sys_clk(sys_clk), .resetn(resetn), .module_select_n_pin(sel_n),
        .module_reset_n(rst_n), .low_power_request(lp_req),
        .flag_condition(flag_condition), .status_read(status_read),
        .mgmt_enable(mgmt_en), .user_settings_reset(usr_rst), .data_not_ready(dnr),
        .low_power_mode(lp_mode), .interrupt_n_o(int_o), .interrupt_n_oe(int_oe),
        .module_present_n_o(prs_o), .module_present_n_oe(prs_oe), .init_state(init_state));

    host_model u_host_model (
        .sys_clk(sys_clk), .interrupt_n_o(int_o), .interrupt_n_oe(int_oe),
        .module_present_n_o(prs_o), .module_present_n_oe(prs_oe),
        .module_select_n_pin(sel_n), .module_reset_n(rst_n), .low_power_request(lp_req),
        .interrupt_n(int_line), .module_present_n(prs_line));

    task automatic chk(input string what, input logic [1:0] seen, input logic [1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // host treats status as invalid until data_not_ready drops
    // bounded wait for the end of initialisation, counting cycles
    task automatic wait_ready(output int cyc);
        cyc = 0;
        while (dnr !== 1'b0 && cyc < 200) begin
            @(negedge sys_clk);
            cyc++;
        end
    endtask : wait_ready

    // host reads the flags after an interrupt
    task automatic host_read();
        @(negedge sys_clk);
        status_read = 1'b1;
        @(negedge sys_clk);
        status_read = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask : host_read

    task automatic t_powerup();
        int c;
        wait_ready(c);
        chk("init_span", c >= INI_CYC && c <= INI_CYC + 8, 1'b1);
        chk("init_state", init_state, ST_READY);
        chk("int_done", int_line, 1'b0);
        host_read();
        chk("int_cleared", int_line, 1'b1);
    endtask : t_powerup

    task automatic t_pins();
        chk("present", prs_line, 1'b0);
        chk("int_drive", int_o, 1'b0);
        u_host_model.set_pins(1'b0, 1'b1);
        repeat (4) @(negedge sys_clk);
        chk("mgmt_sel", mgmt_en, 1'b1);
        chk("lp_on", lp_mode, 1'b1);
        u_host_model.set_pins(1'b1, 1'b0);
        repeat (4) @(negedge sys_clk);
        chk("mgmt_desel", mgmt_en, 1'b0);
        chk("lp_off", lp_mode, 1'b0);
    endtask : t_pins

    // a read while a flag is still pending must not release the line
    task automatic t_flag();
        @(negedge sys_clk);
        flag_condition = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("int_flag", int_line, 1'b0);
        host_read();
        chk("int_pending", int_line, 1'b0);
        flag_condition = 1'b0;
        host_read();
        chk("int_release", int_line, 1'b1);
    endtask : t_flag

    // pulse one sample short of qualifying
    task automatic t_short_reset();
        u_host_model.set_reset(1'b0);
        repeat (RST_CYC - 1) @(negedge sys_clk);
        u_host_model.set_reset(1'b1);
        repeat (8) @(negedge sys_clk);
        chk("short_usr", usr_rst, 1'b0);
        chk("short_state", init_state, ST_READY);
    endtask : t_short_reset

    task automatic t_long_reset();
        int c;
        u_host_model.set_pins(1'b0, 1'b0);
        u_host_model.set_reset(1'b0);
        repeat (RST_CYC + 8) @(negedge sys_clk);
        chk("held_usr", usr_rst, 1'b1);
        chk("held_dnr", dnr, 1'b1);
        chk("held_mgmt", mgmt_en, 1'b0);
        // a flag raised while reset is held must not pull the line
        flag_condition = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("held_int", int_line, 1'b1);
        flag_condition = 1'b0;
        u_host_model.set_reset(1'b1);
        wait_ready(c);
        chk("reinit_span", c >= INI_CYC && c <= INI_CYC + 8, 1'b1);
        chk("reinit_int", int_line, 1'b0);
        host_read();
        u_host_model.set_pins(1'b1, 1'b0);
    endtask : t_long_reset

    task automatic finish_test();
        $display("checks %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    initial begin
        repeat (10) @(negedge sys_clk);
        resetn = 1'b1;
        t_powerup();
        t_pins();
        t_flag();
        t_short_reset();
        t_long_reset();
        finish_test();
    end

    // the tests need some 120 cycles; far beyond that means a hang
    initial begin
        #(20000 * 10);
        num_errors++;
        finish_test();
    end
endmodule : tb_top

`default_nettype wire
